//--- hdl/wdog_reset_pkg.sv
// package: constants and types for the watchdog and initial-reset combiner
package wdog_reset_pkg;

    // register map
    localparam logic [11:0] ctrl_clear_addr = 12'hf76;
    localparam int          wdog_clr_pos    = 0;
    localparam int          tick_clr_pos    = 1;
    localparam logic [3:0]  ctrl_read_value = 4'h0;
    localparam logic [11:0] status_addr     = 12'hf77;

    // synchroniser reset levels: pin high, oscillator stopped, tick low, not halted
    localparam logic [3:0]  pin_sync_rst    = 4'h1;
    localparam logic [3:0]  key_sync_rst    = 4'hf;

    // clock and times
    localparam int clk_hz          = 10_000_000;
    localparam int low_freq_oscillator_hz         = 32_768;
    localparam int pin_min_us      = 2_000;
    localparam int key_min_ms      = 2_000;
    localparam int pin_min_cycles  = (pin_min_us * (clk_hz / 1_000_000));
    localparam int key_min_cycles  = (key_min_ms * (clk_hz / 1_000));

    // watchdog: timeout on the next tick once the count of 1 Hz ticks is at this value
    localparam logic [1:0] wdog_timeout_cnt = 2'h3;

    // key-pattern option
    typedef enum logic [1:0] {
        key_off     = 2'h0,
        key_k01     = 2'h1,
        key_k012    = 2'h3,
        key_k0123   = 2'h2
    } key_mode_e;

    // core state after initial reset
    localparam logic [7:0] pc_step_init   = 8'h00;
    localparam logic [3:0] pc_page_init   = 4'h1;
    localparam logic       pc_bank_init   = 1'h0;
    localparam logic [3:0] next_page_init = 4'h1;
    localparam logic       next_bank_init = 1'h0;
    localparam logic       int_flag_init  = 1'h0;

    typedef struct packed {
        logic [7:0] pc_step_field;
        logic [3:0] pc_page_field;
        logic       pc_bank_field;
        logic [3:0] next_page_pointer;
        logic       next_bank_pointer;
        logic       int_flag;
    } core_init_s;

    localparam core_init_s core_init_value = '{
        pc_step_field:     pc_step_init,
        pc_page_field:     pc_page_init,
        pc_bank_field:     pc_bank_init,
        next_page_pointer: next_page_init,
        next_bank_pointer: next_bank_init,
        int_flag:          int_flag_init
    };

    // reset source flags
    typedef struct packed {
        logic pin;
        logic keys;
        logic osc;
        logic wdog;
    } reset_src_s;

endpackage

//--- hdl/wdog_reset.sv
// watchdog timer and initial-reset combiner
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns

module wdog_reset
    import wdog_reset_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    // register port
    input  wire logic [11:0] reg_addr,
    input  wire logic [3:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [3:0]  reg_rdata,
    // tick timer link
    input  wire logic        tick_1hz,
    output logic             tick_timer_clear,
    // pins and status
    input  wire logic        reset_pin_n,
    input  wire logic [3:0]  key_inputs_zero_to_three,
    input  wire logic        low_freq_oscillator_running,
    input  wire logic [1:0]  key_mode,
    input  wire logic        core_halted,
    // core reset
    output logic             init_reset,
    output core_init_s       core_init
);

    logic       rst_sync1_ff;
    logic       rst_sync2_ff;
    logic       rst_n;
    logic [3:0] pin_sync1_ff;
    logic [3:0] pin_sync2_ff;
    logic [3:0] key_sync1_ff;
    logic [3:0] key_sync2_ff;
    logic [1:0] wdog_cnt_ff;
    logic [$clog2(pin_min_cycles+1)-1:0] pin_cnt_ff;
    logic [$clog2(key_min_cycles+1)-1:0] key_cnt_ff;
    reset_src_s src_ff;
    reset_src_s nxt_src;
    logic       wr_ctrl;
    logic       wdog_clr;
    logic       tick_clr;
    logic       keys_hit;
    logic       wdog_fire;

    // two-flop synchroniser on the asynchronous reset release
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync1_ff <= 1'b0;
            rst_sync2_ff <= 1'b0;
        end else begin
            rst_sync1_ff <= 1'b1;
            rst_sync2_ff <= rst_sync1_ff;
        end
    end
    assign rst_n = rst_sync2_ff;

    // pins pass two flops; bit0 pin, bit1 oscillator ok, bit2 tick, bit3 halted
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            // oscillator reads as stopped so the reset cannot drop while the flops fill
            pin_sync1_ff <= pin_sync_rst;
            pin_sync2_ff <= pin_sync_rst;
            key_sync1_ff <= key_sync_rst;
            key_sync2_ff <= key_sync_rst;
        end else if (clk_en) begin
            pin_sync1_ff <= {core_halted, tick_1hz, low_freq_oscillator_running, reset_pin_n};
            pin_sync2_ff <= pin_sync1_ff;
            key_sync1_ff <= key_inputs_zero_to_three;
            key_sync2_ff <= key_sync1_ff;
        end
    end

    function automatic logic key_match(input logic [1:0] mode, input logic [3:0] k);
        case (key_mode_e'(mode))
            key_off:   key_match = 1'b0;
            key_k01:   key_match = (k[1:0] == 2'h0);
            key_k012:  key_match = (k[2:0] == 3'h0);
            key_k0123: key_match = (k == 4'h0);
            default:   key_match = 1'b0;
        endcase
    endfunction

    assign keys_hit = key_match(key_mode, key_sync2_ff);
    assign wr_ctrl  = reg_wr && (reg_addr == ctrl_clear_addr);
    assign wdog_clr = wr_ctrl && reg_wdata[wdog_clr_pos];
    assign tick_clr = wr_ctrl && reg_wdata[tick_clr_pos];

    // tick edge; the halt input is deliberately not used to gate counting
    logic tick_d_ff;
    logic tick_rise;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_d_ff <= 1'b0;
        end else if (clk_en) begin
            tick_d_ff <= pin_sync2_ff[2];
        end
    end
    assign tick_rise = pin_sync2_ff[2] && !tick_d_ff;

    // count 1 Hz ticks: timeout at count 3 after clear gives 3-4 s
    assign wdog_fire = (wdog_cnt_ff == wdog_timeout_cnt) && (tick_rise || tick_clr);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdog_cnt_ff <= 2'h0;
        end else if (clk_en) begin
            if (init_reset || wdog_clr) begin
                wdog_cnt_ff <= 2'h0;
            end else if (tick_rise || tick_clr) begin
                wdog_cnt_ff <= wdog_cnt_ff + 2'h1;
            end
        end
    end

    // pin noise filter: low must persist 2 ms
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_cnt_ff <= '0;
        end else if (clk_en) begin
            if (pin_sync2_ff[0]) begin
                pin_cnt_ff <= '0;
            end else if (pin_cnt_ff != ($bits(pin_cnt_ff))'(pin_min_cycles)) begin
                pin_cnt_ff <= pin_cnt_ff + 1'b1;
            end
        end
    end

    // key pattern hold timer: 2 s
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            key_cnt_ff <= '0;
        end else if (clk_en) begin
            if (!keys_hit) begin
                key_cnt_ff <= '0;
            end else if (key_cnt_ff != ($bits(key_cnt_ff))'(key_min_cycles)) begin
                key_cnt_ff <= key_cnt_ff + 1'b1;
            end
        end
    end

    // reset sources; pin reset ends as soon as pin is high again
    always_comb begin
        nxt_src.pin  = !pin_sync2_ff[0] &&
                       (pin_cnt_ff == ($bits(pin_cnt_ff))'(pin_min_cycles));
        nxt_src.keys = keys_hit &&
                       (key_cnt_ff == ($bits(key_cnt_ff))'(key_min_cycles));
        nxt_src.osc  = !pin_sync2_ff[1];
        nxt_src.wdog = wdog_fire;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_ff     <= '0;
            init_reset <= 1'b1;
        end else if (clk_en) begin
            src_ff     <= nxt_src;
            init_reset <= |nxt_src;
        end
    end

    // core init values driven every cycle, whether or not initial reset is active
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_init <= core_init_value;
        end else if (clk_en) begin
            core_init <= core_init_value;
        end
    end

    // tick timer clear pulse out
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_timer_clear <= 1'b0;
        end else if (clk_en) begin
            tick_timer_clear <= tick_clr;
        end
    end

    // read data one cycle later; clear bits always read zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 4'h0;
        end else if (clk_en) begin
            if (reg_rd && reg_addr == ctrl_clear_addr) begin
                reg_rdata <= ctrl_read_value;
            end else if (reg_rd && reg_addr == status_addr) begin
                reg_rdata <= {src_ff.pin, src_ff.keys, src_ff.osc, src_ff.wdog};
            end else begin
                reg_rdata <= 4'h0;
            end
        end
    end

    // assertions
    a_clear_zeroes_cnt: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && wdog_clr) |=> (wdog_cnt_ff == 2'h0))
        else $error("watchdog count not zeroed by clear");

    a_zero_read_back: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && reg_rd && reg_addr == ctrl_clear_addr) |=> (reg_rdata == 4'h0))
        else $error("clear register read nonzero");

    a_wdog_fires_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && wdog_fire) |=> init_reset)
        else $error("watchdog timeout gave no reset");

    a_reset_clears_cnt: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && init_reset) |=> (wdog_cnt_ff == 2'h0))
        else $error("reset left watchdog count");

    a_tick_clr_steps: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && tick_clr && !wdog_clr && !init_reset)
        |=> (wdog_cnt_ff == $past(wdog_cnt_ff) + 2'h1))
        else $error("tick clear did not step watchdog");

    a_osc_holds_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && !pin_sync2_ff[1]) |=> init_reset)
        else $error("no reset while oscillator stopped");

    a_keys_off_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (key_mode == 2'h0) |-> !keys_hit)
        else $error("key pattern matched while disabled");

    a_pin_filter: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && nxt_src.pin) |-> (pin_cnt_ff == ($bits(pin_cnt_ff))'(pin_min_cycles)))
        else $error("pin reset before filter time");

    a_init_values: assert property (@(posedge sys_clk) disable iff (!rst_n)
        init_reset |-> (core_init.pc_page_field == 4'h1 && core_init.pc_step_field == 8'h00))
        else $error("core init values wrong");

    // watchdog timeout: count at its last step and one counted step in the same cycle
    sequence s_wdog_armed;
        clk_en && (wdog_cnt_ff == wdog_timeout_cnt) && !init_reset && !wdog_clr;
    endsequence

    sequence s_wdog_step;
        tick_rise || tick_clr;
    endsequence

    a_wdog_timeout: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (s_wdog_armed ##0 s_wdog_step) |=> init_reset)
        else $error("watchdog timeout sequence gave no reset");

    a_timeout_restarts: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (s_wdog_armed ##0 s_wdog_step) |=> (wdog_cnt_ff == 2'h0) ##1 (wdog_cnt_ff == 2'h0))
        else $error("watchdog did not restart from zero");

    a_halt_counts: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && pin_sync2_ff[3] && tick_rise && !tick_clr && !wdog_clr && !init_reset)
        |=> (wdog_cnt_ff == $past(wdog_cnt_ff) + 2'h1))
        else $error("watchdog stopped while core halted");

    a_keys_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && !keys_hit) |=> !src_ff.keys)
        else $error("key reset without pattern");

    a_pin_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && pin_sync2_ff[0]) |=> !src_ff.pin)
        else $error("pin reset held after pin high");

    a_source_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && (nxt_src != '0)) |=> init_reset)
        else $error("reset source gave no reset");

    a_source_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && (nxt_src == '0)) |=> !init_reset)
        else $error("reset without any source");

    a_tick_clear_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en |=> (tick_timer_clear == $past(tick_clr)))
        else $error("tick timer clear pulse wrong");

    a_read_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clk_en && !reg_rd) |=> (reg_rdata == 4'h0))
        else $error("read data outside read cycle");

    a_key_pair_match: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (key_mode == key_k01 && key_sync2_ff[1:0] == 2'h0) |-> keys_hit)
        else $error("two-key pattern not matched");

    a_key_four_needs: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (key_mode == key_k0123 && key_sync2_ff[3]) |-> !keys_hit)
        else $error("four-key pattern matched with key three high");

    a_init_pointers: assert property (@(posedge sys_clk) disable iff (!rst_n)
        init_reset |-> (core_init.next_page_pointer == next_page_init &&
                        core_init.next_bank_pointer == next_bank_init &&
                        core_init.int_flag == int_flag_init &&
                        core_init.pc_bank_field == pc_bank_init))
        else $error("core pointer init values wrong");

endmodule

//--- dv/tick_src_model.sv
// tick timer model that feeds the 1 Hz tick level to the watchdog
`timescale 1ns/1ns
module tick_src_model (
    // clock
    input  wire logic sys_clk,
    // control from bench and block
    input  wire logic fire,
    input  wire logic tick_timer_clear,
    // tick level
    output logic      tick_1hz
);
    // ticks are shortened to a few cycles so that a run stays short
    logic [1:0] hold_ff = 2'h0;

    always_ff @(posedge sys_clk) begin
        if (tick_timer_clear) begin
            hold_ff <= 2'h0;
        end else if (fire) begin
            hold_ff <= 2'h3;
        end else if (hold_ff != 2'h0) begin
            hold_ff <= hold_ff - 2'h1;
        end
    end

    assign tick_1hz = (hold_ff != 2'h0);
endmodule

//--- dv/wdog_reset_tb.sv
// self-checking bench for the watchdog and initial-reset combiner
`timescale 1ns/1ns
module wdog_reset_tb;
    import wdog_reset_pkg::*;

    logic        sys_clk      = 1'b0;
    logic        resetn       = 1'b0;
    logic [11:0] reg_addr     = 12'h000;
    logic [3:0]  reg_wdata    = 4'h0;
    logic        reg_wr       = 1'b0;
    logic        reg_rd       = 1'b0;
    logic [3:0]  reg_rdata;
    logic        tick_1hz;
    logic        tick_timer_clear;
    logic        reset_pin_n  = 1'b1;
    logic [3:0]  keys         = 4'hf;
    logic        low_freq_oscillator_running = 1'b0;
    logic [1:0]  key_mode     = 2'h0;
    logic        core_halted  = 1'b0;
    logic        init_reset;
    core_init_s  core_init;
    logic        fire         = 1'b0;
    logic        saw_rst      = 1'b0;
    int          ttc_cnt      = 0;
    int          err_total    = 0;
    int          num_checks   = 0;
    localparam logic [17:0] init_exp = {8'h00, 4'h1, 1'h0, 4'h1, 1'h0, 1'h0};

    always #50 sys_clk = ~sys_clk;

    // sticky observers sampled away from the active edge
    always @(negedge sys_clk) begin
        if (init_reset === 1'b1) saw_rst = 1'b1;
        if (tick_timer_clear === 1'b1) ttc_cnt++;
    end

    wdog_reset uut (.sys_clk(sys_clk), .resetn(resetn), .clk_en(1'b1), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tick_1hz(tick_1hz), .tick_timer_clear(tick_timer_clear), .reset_pin_n(reset_pin_n),
        .key_inputs_zero_to_three(keys), .low_freq_oscillator_running(low_freq_oscillator_running), .key_mode(key_mode),
        .core_halted(core_halted), .init_reset(init_reset), .core_init(core_init));

    tick_src_model far (.sys_clk(sys_clk), .fire(fire), .tick_timer_clear(tick_timer_clear),
        .tick_1hz(tick_1hz));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [3:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [3:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(negedge sys_clk);
        chk("reg_rdata", reg_rdata, exp);
    endtask

    // each tick passes the synchroniser before the next one starts
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge sys_clk) fire <= 1'b1;
            @(posedge sys_clk) fire <= 1'b0;
            repeat (8) @(posedge sys_clk);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge sys_clk);
        err_total++;
        wrap_up();
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        // first design edges after release: reset must not drop before the oscillator runs
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("osc hold early", init_reset, 1'b1);
        repeat (7) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("osc hold", init_reset, 1'b1);
        chk("core_init", core_init, init_exp);
        rd(status_addr, 4'h2);
        @(posedge sys_clk) low_freq_oscillator_running <= 1'b1;
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("osc release", init_reset, 1'b0);
        wr(ctrl_clear_addr, 4'h1);
        rd(ctrl_clear_addr, 4'h0);
        rd(12'h000, 4'h0);
        // second round relies on the reset itself having cleared the count
        for (int i = 0; i < 2; i++) begin
            @(posedge sys_clk);
            core_halted <= i[0];
            saw_rst = 1'b0;
            ticks(3);
            chk("three ticks", saw_rst, 1'b0);
            ticks(1);
            chk("fourth tick", saw_rst, 1'b1);
        end
        core_halted <= 1'b0;
        wr(ctrl_clear_addr, 4'h1);
        ticks(3);
        wr(ctrl_clear_addr, 4'h1);
        saw_rst = 1'b0;
        ticks(3);
        chk("cleared count", saw_rst, 1'b0);
        wr(ctrl_clear_addr, 4'h0);
        ticks(1);
        chk("write zero", saw_rst, 1'b1);
        wr(ctrl_clear_addr, 4'h1);
        ticks(3);
        wr(12'hf75, 4'h3);
        saw_rst = 1'b0;
        ttc_cnt = 0;
        wr(ctrl_clear_addr, 4'h2);
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("tick clear pulse", ttc_cnt, 1);
        chk("tick clear step", saw_rst, 1'b1);
        // a full key hold takes seconds, so only short presses are tried;
        // keys 0-2 low with key 3 high match only the two- and three-key options
        saw_rst = 1'b0;
        for (int m = 0; m < 4; m++) begin
            @(posedge sys_clk);
            key_mode <= m[1:0];
            keys     <= 4'h8;
            repeat (200) @(posedge sys_clk);
            @(negedge sys_clk);
            chk("key pattern", uut.key_cnt_ff != '0, m == 1 || m == 3);
            @(posedge sys_clk);
            keys     <= 4'hf;
            repeat (4) @(posedge sys_clk);
        end
        chk("short key press", saw_rst, 1'b0);
        saw_rst = 1'b0;
        reset_pin_n <= 1'b0;
        repeat (100) @(posedge sys_clk);
        reset_pin_n <= 1'b1;
        repeat (10) @(posedge sys_clk);
        chk("pin glitch", saw_rst, 1'b0);
        // leave the watchdog part way so that the pin reset must clear it
        ticks(2);
        reset_pin_n <= 1'b0;
        repeat (pin_min_cycles + 10) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("pin reset", init_reset, 1'b1);
        chk("pin core_init", core_init, init_exp);
        @(posedge sys_clk) reset_pin_n <= 1'b1;
        for (int i = 0; i < 20 && init_reset !== 1'b0; i++) @(negedge sys_clk);
        chk("pin release", init_reset, 1'b0);
        saw_rst = 1'b0;
        ticks(3);
        chk("reset clears count", saw_rst, 1'b0);
        @(posedge sys_clk) low_freq_oscillator_running <= 1'b0;
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("osc lost", init_reset, 1'b1);
        wrap_up();
    end
endmodule
